// [ssx_exec.sv]
`timescale 1ns/100ps
`default_nettype none
module ssx_exec (
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    input  wire logic              req_valid,
    input  wire ssx_pkg::ssx_req_s req,
    output logic [7:0]             acc_q,
    output logic                   signed_wrap_flag_q,
    output logic                   zero_flag_q,
    output logic                   auxiliary_borrow_flag_q,
    output logic                   carry_flag_q,
    output logic                   mem_we_q,
    output logic [7:0]             mem_wdata_q,
    output logic                   skip_next_q,
    output logic                   dummy_cycle_q,
    output logic                   busy_q
);
    // ----------------------------------------------------------------
    // Decode and arithmetic
    // ----------------------------------------------------------------
    ssx_pkg::ssx_sub_s  sub_res;
    ssx_pkg::ssx_state_e state_q;
    logic [7:0]         sub_b;
    logic               take;
    logic               is_zero;

    function automatic logic is_sub(input ssx_pkg::ssx_op_e op);
        is_sub = (op == ssx_pkg::SSX_OP_SUB_MEM_ACC) || (op == ssx_pkg::SSX_OP_SUB_MEM_MEM)
              || (op == ssx_pkg::SSX_OP_SUB_IMM);
    endfunction : is_sub

    function automatic logic [7:0] swap_nib(input logic [7:0] v);
        swap_nib = {v[3:0], v[7:4]};
    endfunction : swap_nib

    assign sub_b   = (req.op == ssx_pkg::SSX_OP_SUB_IMM) ? req.imm : req.mem_data;  // RQ4
    assign take    = clk_en && req_valid && (state_q == ssx_pkg::SSX_ST_EXEC);
    assign is_zero = (req.mem_data == 8'h00);

    ssx_sub u_sub (
        .a   (acc_q),
        .b   (sub_b),
        .res (sub_res)
    );

    // ----------------------------------------------------------------
    // Accumulator
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            acc_q <= ssx_pkg::ACC_RESET;
        end else if (take) begin
            unique case (req.op)
                ssx_pkg::SSX_OP_SUB_MEM_ACC: acc_q <= sub_res.diff;             // RQ1
                ssx_pkg::SSX_OP_SUB_IMM:     acc_q <= sub_res.diff;             // RQ4
                ssx_pkg::SSX_OP_SWAP_ACC:    acc_q <= swap_nib(req.mem_data);   // RQ6
                ssx_pkg::SSX_OP_SKIP_LOAD:   acc_q <= req.mem_data;             // RQ11
                default:                     acc_q <= acc_q;                    // RQ3
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Flags
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            signed_wrap_flag_q      <= ssx_pkg::FLAGS_RESET[ssx_pkg::FLAG_WRAP];
            zero_flag_q             <= ssx_pkg::FLAGS_RESET[ssx_pkg::FLAG_ZERO];
            auxiliary_borrow_flag_q <= ssx_pkg::FLAGS_RESET[ssx_pkg::FLAG_AUX];
            carry_flag_q            <= ssx_pkg::FLAGS_RESET[ssx_pkg::FLAG_C];
        end else if (take && is_sub(req.op)) begin                     // RQ1
            signed_wrap_flag_q      <= sub_res.wrap;                   // RQ12
            zero_flag_q             <= sub_res.zero;                   // RQ12
            auxiliary_borrow_flag_q <= sub_res.aux;                    // RQ12
            carry_flag_q            <= sub_res.carry;                  // RQ2
        end
    end

    // ----------------------------------------------------------------
    // Memory write-back
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mem_we_q    <= 1'b0;
            mem_wdata_q <= ssx_pkg::WDATA_RESET;
        end else if (clk_en) begin
            mem_we_q <= 1'b0;
            if (take) begin
                unique case (req.op)
                    ssx_pkg::SSX_OP_SUB_MEM_MEM: begin
                        mem_we_q    <= 1'b1;                            // RQ3
                        mem_wdata_q <= sub_res.diff;
                    end
                    ssx_pkg::SSX_OP_SWAP_MEM: begin
                        mem_we_q    <= 1'b1;                            // RQ5
                        mem_wdata_q <= swap_nib(req.mem_data);
                    end
                    ssx_pkg::SSX_OP_SKIP_MEM: begin
                        mem_we_q    <= 1'b1;                            // RQ7
                        mem_wdata_q <= req.mem_data;
                    end
                    default: mem_wdata_q <= mem_wdata_q;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Skip sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q       <= ssx_pkg::SSX_ST_EXEC;
            skip_next_q   <= 1'b0;
            dummy_cycle_q <= 1'b0;
            busy_q        <= 1'b0;
        end else if (clk_en) begin
            unique case (state_q)
                ssx_pkg::SSX_ST_EXEC: begin
                    skip_next_q   <= 1'b0;
                    dummy_cycle_q <= 1'b0;
                    busy_q        <= 1'b0;
                    if (take && is_zero && ((req.op == ssx_pkg::SSX_OP_SKIP_MEM)
                                         || (req.op == ssx_pkg::SSX_OP_SKIP_LOAD))) begin
                        state_q       <= ssx_pkg::SSX_ST_DUMMY;        // RQ9
                        skip_next_q   <= 1'b1;                         // RQ8
                        dummy_cycle_q <= 1'b1;                         // RQ11
                        busy_q        <= 1'b1;
                    end                                                // RQ10
                end
                ssx_pkg::SSX_ST_DUMMY: begin
                    state_q       <= ssx_pkg::SSX_ST_EXEC;
                    skip_next_q   <= 1'b0;
                    dummy_cycle_q <= 1'b0;
                    busy_q        <= 1'b0;
                end
            endcase
        end
    end
endmodule : ssx_exec
`default_nettype wire

// [ssx_pkg.sv]
// Behaviour
// (RQ1) Subtract memory byte from accumulator, result to accumulator, update four flags.
// (RQ2) Carry is inverted borrow: 0 when difference negative, else 1.
// (RQ3) Accumulator minus memory written back to memory; accumulator kept; flags updated.
// (RQ4) Subtract instruction immediate from accumulator into accumulator; update four flags.
// (RQ5) Exchange nibbles of memory byte and write back in place.
// (RQ6) Swapped memory nibbles go to accumulator; memory and flags untouched.
// (RQ7) Skip-when-zero reads the byte and writes it back unchanged; no flags.
// (RQ8) Tested byte zero suppresses the next sequential instruction.
// (RQ9) Taken skip inserts a dummy cycle; instruction takes two cycles.
// (RQ10) Nonzero byte continues normally without a dummy cycle.
// (RQ11) Skip-with-load copies byte to accumulator, skips if zero; no flags.
// (RQ12) 8-bit operands; zero, signed wrap, and bit-3 inverted borrow flags.
package ssx_pkg;

    localparam logic [7:0] ACC_RESET   = 8'h00;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [7:0] WDATA_RESET = 8'h00;
    localparam int         FLAG_C      = 0;
    localparam int         FLAG_AUX    = 1;
    localparam int         FLAG_ZERO   = 2;
    localparam int         FLAG_WRAP   = 3;

    typedef enum logic [2:0] {
        SSX_OP_SUB_MEM_ACC = 3'b000,
        SSX_OP_SUB_MEM_MEM = 3'b001,
        SSX_OP_SUB_IMM     = 3'b010,
        SSX_OP_SWAP_MEM    = 3'b011,
        SSX_OP_SWAP_ACC    = 3'b100,
        SSX_OP_SKIP_MEM    = 3'b101,
        SSX_OP_SKIP_LOAD   = 3'b110,
        SSX_OP_NONE        = 3'b111
    } ssx_op_e;

    typedef enum logic [0:0] {
        SSX_ST_EXEC  = 1'b0,
        SSX_ST_DUMMY = 1'b1
    } ssx_state_e;

    // Request of one instruction
    typedef struct packed {
        ssx_op_e    op;
        logic [7:0] mem_data;
        logic [7:0] imm;
    } ssx_req_s;

    // Result of the subtractor
    typedef struct packed {
        logic [7:0] diff;
        logic       wrap;
        logic       zero;
        logic       aux;
        logic       carry;
    } ssx_sub_s;

endpackage : ssx_pkg

// [ssx_sub.sv]
`timescale 1ns/100ps
`default_nettype none
module ssx_sub (
    input  wire logic [7:0]       a,
    input  wire logic [7:0]       b,
    output ssx_pkg::ssx_sub_s     res
);
    logic [8:0] full;
    logic [4:0] low;

    always_comb begin
        full      = {1'b0, a} - {1'b0, b};
        low       = {1'b0, a[3:0]} - {1'b0, b[3:0]};
        res.diff  = full[7:0];
        res.carry = ~full[8];                                          // RQ2
        res.aux   = ~low[4];                                           // RQ12
        res.zero  = (full[7:0] == 8'h00);                              // RQ12
        res.wrap  = (a[7] != b[7]) && (full[7] != a[7]);               // RQ12
    end
endmodule : ssx_sub
`default_nettype wire

// [ssx_exec_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module ssx_exec_monitor (
    input wire logic              clock,
    input wire logic              rst_b,
    input wire logic              clk_en,
    input wire logic              req_valid,
    input wire ssx_pkg::ssx_req_s req,
    input wire logic [7:0]        acc_q,
    input wire logic              carry_flag_q,
    input wire logic              mem_we_q,
    input wire logic [7:0]        mem_wdata_q,
    input wire logic              skip_next_q,
    input wire logic              dummy_cycle_q,
    input wire logic              busy_q
);
    // ------------
    // Port checks
    // ------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Accepted request, one hot by op code
    wire logic [7:0] t  = {8{clk_en && req_valid && !busy_q}} & (8'h01 << req.op);
    wire logic [7:0] md = req.mem_data;
    wire logic [7:0] sw = {md[3:0], md[7:4]};
    sequence s_dummy;
        skip_next_q && dummy_cycle_q && busy_q ##1 (!busy_q || !$past(clk_en));
    endsequence
    chk_sub_acc: assert property (t[0] |=> acc_q == $past(acc_q) - $past(md)
        && carry_flag_q == ($past(acc_q) >= $past(md))) else $error("sub acc");
    chk_sub_mem: assert property (t[1] |=> mem_we_q && acc_q == $past(acc_q)
        && mem_wdata_q == $past(acc_q) - $past(md)) else $error("sub mem");
    chk_sub_imm: assert property (t[2] |=>
        acc_q == $past(acc_q) - $past(req.imm)) else $error("sub imm");
    chk_swap_mem: assert property (t[3] |=> mem_we_q && mem_wdata_q == $past(sw))
        else $error("swap mem");
    chk_swap_acc: assert property (t[4] |=> acc_q == $past(sw) && !mem_we_q
        && $stable(carry_flag_q)) else $error("swap acc");
    chk_skip_taken: assert property (t[5] && md == 8'h00 |=> s_dummy)
        else $error("skip dummy");
    chk_skip_none: assert property (t[5] && md != 8'h00 |=> mem_we_q
        && mem_wdata_q == $past(md) && !skip_next_q && !dummy_cycle_q) else $error("no skip");
    chk_skip_load: assert property (t[6] |=> acc_q == $past(md)
        && skip_next_q == ($past(md) == 8'h00)) else $error("skip load");
endmodule : ssx_exec_monitor
`default_nettype wire

// [tb_subtract_swap_skip_exec.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_subtract_swap_skip_exec;
    logic              clock, rst_b, clk_en, req_valid;
    ssx_pkg::ssx_req_s req;
    logic [7:0]        acc_q, mem_wdata_q, a[4], b[4];
    logic              signed_wrap_flag_q, zero_flag_q, auxiliary_borrow_flag_q, carry_flag_q;
    logic              mem_we_q, skip_next_q, dummy_cycle_q, busy_q;
    logic [11:0]       r;
    int                fail_count, cmp_count, i;
    wire logic [11:0]  st = {signed_wrap_flag_q, zero_flag_q, auxiliary_borrow_flag_q,
                             carry_flag_q, acc_q};
    wire logic [11:0]  mo = {mem_we_q, skip_next_q, dummy_cycle_q, busy_q, mem_wdata_q};
    ssx_exec dut_u (.clock, .rst_b, .clk_en, .req_valid, .req, .acc_q, .signed_wrap_flag_q,
        .zero_flag_q, .auxiliary_borrow_flag_q, .carry_flag_q, .mem_we_q, .mem_wdata_q,
        .skip_next_q, .dummy_cycle_q, .busy_q);
    // ------------
    // Procedures
    // ------------
    function automatic logic [11:0] sub(logic [7:0] x, logic [7:0] y);
        logic [7:0] d;
        d = x - y;
        return {x[7] != y[7] && d[7] != x[7], d == 8'h00, x[3:0] >= y[3:0], x >= y, d};
    endfunction : sub
    task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic run(ssx_pkg::ssx_op_e op, logic [7:0] m, logic [7:0] k, logic h);
        @(posedge clock);
        #1 req_valid = 1'b1;
        req = '{op, m, k};
        @(posedge clock);
        #1 req_valid = h;
    endtask : run
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        req_valid = 1'b0;
        req = '0;
        a = '{8'h80, 8'h10, 8'h05, 8'h01};
        b = '{8'h01, 8'h01, 8'h05, 8'h02};
        fail_count = 0;
        cmp_count = 0;
        repeat (10) @(posedge clock);
        #1 rst_b = 1'b1;
        for (i = 0; i < 4; i++) begin
            run(ssx_pkg::SSX_OP_SKIP_LOAD, a[i], 8'h00, 1'b0);
            r = sub(a[i], b[i]);
            run(ssx_pkg::SSX_OP_SUB_MEM_MEM, b[i], 8'h00, 1'b0);
            chk("sub mem", {4'h8, r[7:0]}, mo);
            chk("sub mem acc", {r[11:8], a[i]}, st);
            run(ssx_pkg::SSX_OP_SUB_IMM, 8'h00, b[i], 1'b0);
            chk("sub imm", r, st);
            run(ssx_pkg::SSX_OP_SKIP_LOAD, a[i], 8'h00, 1'b0);
            run(ssx_pkg::SSX_OP_SUB_MEM_ACC, b[i], 8'h00, 1'b0);
            chk("sub acc", r, st);
        end
        $display("Test subtract done");
        run(ssx_pkg::SSX_OP_SWAP_MEM, 8'hA5, 8'h00, 1'b0);
        chk("swap mem", {4'h8, 8'h5A}, mo);
        r = st;
        run(ssx_pkg::SSX_OP_SWAP_ACC, 8'h3C, 8'h00, 1'b0);
        chk("swap acc", {r[11:8], 8'hC3}, st);
        $display("Test swap done");
        run(ssx_pkg::SSX_OP_SKIP_MEM, 8'h77, 8'h00, 1'b0);
        chk("skip nonzero", {4'h8, 8'h77}, mo);
        r = st;
        run(ssx_pkg::SSX_OP_SKIP_MEM, 8'h00, 8'h00, 1'b1);
        chk("skip zero", {4'hF, 8'h00}, mo);
        clk_en = 1'b0;
        req = '{ssx_pkg::SSX_OP_SUB_IMM, 8'h00, 8'h01};
        @(posedge clock);
        #1 clk_en = 1'b1;
        chk("frozen pulses", {4'hF, 8'h00}, mo);
        chk("frozen state", r, st);
        @(posedge clock);
        #1 req_valid = 1'b0;
        chk("dummy end", 12'h000, mo);
        chk("ignored", r, st);
        run(ssx_pkg::SSX_OP_SKIP_LOAD, 8'h00, 8'h00, 1'b0);
        chk("skip load", {r[11:8], 8'h00}, st);
        chk("skip load pulses", {4'h7, 8'h00}, mo);
        $display("Test skip done");
        finish_test();
    end
endmodule : tb_subtract_swap_skip_exec
bind ssx_exec ssx_exec_monitor mon_u (.clock, .rst_b, .clk_en, .req_valid, .req, .acc_q,
    .carry_flag_q, .mem_we_q, .mem_wdata_q, .skip_next_q, .dummy_cycle_q, .busy_q);
`default_nettype wire
